// File: src/flash_prot_consts.svh
// Register offsets, field positions and address ranges of the flash protection block.
// Assumes inclusion by the design module only.
`ifndef FLASH_PROT_CONSTS_SVH
`define FLASH_PROT_CONSTS_SVH
// ============================================================
// Register map
`define PROT_CTRL_OFFSET 4'h4
`define STATUS_OFFSET 4'h5
`define CMD_OFFSET 4'h6
`define NV_BYTE_ADDR 16'hff0d
`define PROT_RESET 8'hff
// ============================================================
// Field positions and address ranges
`define POLARITY_BIT 7
`define SPARE_BIT 6
`define HIGH_DIS_BIT 5
`define HIGH_SIZE_LSB 3
`define LOW_DIS_BIT 2
`define LOW_SIZE_LSB 0
`define VIOL_BIT 5
`define HIGH_BASE_00 16'hf800
`define HIGH_BASE_01 16'hf000
`define HIGH_BASE_10 16'he000
`define HIGH_BASE_11 16'hc000
`define LOW_BASE 16'h4000
`define LOW_TOP_00 16'h43ff
`define LOW_TOP_01 16'h47ff
`define LOW_TOP_10 16'h4fff
`define LOW_TOP_11 16'h5fff
`endif

// File: src/flash_prot_pkg.sv
// Types shared by the flash protection block.
// Assumes the constants header sits beside it.
package flash_prot_pkg;
    typedef enum logic [1:0] {
        LOAD_REQ = 2'b00,
        LOAD_WAIT = 2'b01,
        RUN = 2'b11
    } load_state_e;
    typedef enum logic [1:0] {
        CMD_PROGRAM = 2'h0,
        CMD_SECTOR_ERASE = 2'h1,
        CMD_MASS_ERASE = 2'h2,
        CMD_OTHER = 2'h3
    } cmd_kind_e;
endpackage

// File: src/flash_sector_protection.sv
// Flash sector protection logic with an Avalon-MM register slave.
// Assumes the flash array answers the reset byte read and carries out accepted commands.
//
// Behaviour
// RULE_01: Protection register reads back its contents in all modes.
// RULE_02: Polarity bit 7 may only go from one to zero.
// RULE_03: Low size field writable only while low disable is set.
// RULE_04: High size field writable only while high disable is set.
// RULE_05: Protection register loads from flash byte 0xFF0D after reset.
// RULE_06: Software unprotects the top sector before reprogramming the stored byte.
// RULE_07: Program or erase into protected space is refused and sets violation.
// RULE_08: Mass erase needs polarity and both disables set, else violation.
// RULE_09: Polarity one: cleared disable protects range; zero: marks it unprotected.
// RULE_10: Polarity one: disables select protection of low and high ranges.
// RULE_11: Polarity zero: whole array protected except cleared ranges.
// RULE_12: High size codes give 2, 4, 8 or 16 KB ending at 0xFFFF.
// RULE_13: Low size codes give 1, 2, 4 or 8 KB starting at 0x4000.
// RULE_14: High disable at bit 5; one removes the high range.
// RULE_15: Low disable at bit 2; one removes the low range.
// RULE_16: Software leaves spare bit 6 erased.
// RULE_17: Software may tighten protection after the reset load.
// RULE_18: Writes that would loosen protection leave the register unchanged.
// RULE_19: Violation flag blocks commands; cleared by writing one.
// RULE_20: Range check happens in the cycle the command is accepted.
`include "flash_prot_consts.svh"

module flash_sector_protection (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Avalon-MM slave
    input wire logic [3:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWriteData,
    output logic [31:0] avsReadData,
    output logic avsWaitRequest,
    // Reset load of the stored protection byte
    output logic nvReadReq,
    output logic [15:0] nvReadAddr,
    input wire logic nvReadValid,
    input wire logic [7:0] nvReadData,
    // Command request from the command controller
    input wire logic cmdValid,
    input wire flash_prot_pkg::cmd_kind_e cmdKind,
    input wire logic [15:0] cmdAddr,
    output logic cmdAccept,
    output logic cmdRefuse,
    // Status
    output logic violation
);
    import flash_prot_pkg::*;

    typedef struct packed {
        load_state_e st;
        logic [7:0] prot;
        logic viol;
        logic ack;
        logic [31:0] rdata;
        logic accept;
        logic refuse;
    } state_s;

    state_s cur_q;
    state_s nxt_d;

    // Contents while reset is held; the byte stays all ones until the load.
    localparam state_s RESET_STATE = '{st: LOAD_REQ, prot: `PROT_RESET, viol: 1'b0,
        ack: 1'b0, rdata: 32'h0, accept: 1'b0, refuse: 1'b0};

    // ============================================================
    // Protection decode
    function automatic logic inHigh(input logic [1:0] sz, input logic [15:0] a);
        logic [15:0] base;
        base = `HIGH_BASE_00;
        case (sz)
            2'b00: base = `HIGH_BASE_00;
            2'b01: base = `HIGH_BASE_01;
            2'b10: base = `HIGH_BASE_10;
            default: base = `HIGH_BASE_11;
        endcase
        return a >= base; // RULE_12
    endfunction

    function automatic logic inLow(input logic [1:0] sz, input logic [15:0] a);
        logic [15:0] top;
        top = `LOW_TOP_00;
        case (sz)
            2'b00: top = `LOW_TOP_00;
            2'b01: top = `LOW_TOP_01;
            2'b10: top = `LOW_TOP_10;
            default: top = `LOW_TOP_11;
        endcase
        return (a >= `LOW_BASE) && (a <= top); // RULE_13
    endfunction

    function automatic logic isProtected(input logic [7:0] p, input logic [15:0] a);
        logic hit;
        logic lowHit;
        hit = !p[`HIGH_DIS_BIT] && inHigh(p[`HIGH_SIZE_LSB+:2], a); // RULE_14
        lowHit = !p[`LOW_DIS_BIT] && inLow(p[`LOW_SIZE_LSB+:2], a); // RULE_15
        if (p[`POLARITY_BIT]) begin
            return hit || lowHit; // RULE_10
        end
        return !(hit || lowHit); // RULE_11
    endfunction

    // Scenario number from polarity and the two disables.
    function automatic logic [2:0] scenario(input logic [7:0] p);
        return {p[`POLARITY_BIT], p[`HIGH_DIS_BIT], p[`LOW_DIS_BIT]};
    endfunction

    // ============================================================
    // Register access

    // Read data for one register index; other indexes read zero.
    function automatic logic [31:0] readWord(input logic [3:0] a, input logic [7:0] p,
        input logic v);
        logic [31:0] w;

        w = 32'h0;
        if (a == `PROT_CTRL_OFFSET) begin
            w[7:0] = p; // RULE_01
        end else if (a == `STATUS_OFFSET) begin
            w[`VIOL_BIT] = v; // RULE_19
        end
        return w;
    endfunction

    // Field masking of a software write to the protection register.
    function automatic logic [7:0] maskedWrite(input logic [7:0] o, input logic [7:0] r);
        logic [7:0] c;

        c = o;
        c[`POLARITY_BIT] = o[`POLARITY_BIT] & r[`POLARITY_BIT]; // RULE_02
        c[`SPARE_BIT] = r[`SPARE_BIT];
        c[`HIGH_DIS_BIT] = r[`HIGH_DIS_BIT];
        c[`LOW_DIS_BIT] = r[`LOW_DIS_BIT];
        if (o[`HIGH_DIS_BIT]) begin
            c[`HIGH_SIZE_LSB+:2] = r[`HIGH_SIZE_LSB+:2]; // RULE_04
        end
        if (o[`LOW_DIS_BIT]) begin
            c[`LOW_SIZE_LSB+:2] = r[`LOW_SIZE_LSB+:2]; // RULE_03
        end
        return c;
    endfunction

    // Protection verdict for one command against the current byte.
    function automatic logic cmdBad(input cmd_kind_e k, input logic [7:0] p,
        input logic [15:0] a);
        logic b;

        b = 1'b0;
        if (k == CMD_MASS_ERASE) begin
            b = scenario(p) != 3'b111; // RULE_08
        end else if (k != CMD_OTHER) begin
            b = isProtected(p, a); // RULE_07 RULE_09
        end
        return b;
    endfunction

    // Allowed move: protected areas only grow in every address.
    function automatic logic tighter(input logic [7:0] o, input logic [7:0] n);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < 4; i++) begin
            for (int j = 0; j < 4; j++) begin
                if (isProtected(o, 16'(`HIGH_BASE_11 + 16'(i) * 16'h1000))
                    && !isProtected(n, 16'(`HIGH_BASE_11 + 16'(i) * 16'h1000))) begin
                    ok = 1'b0;
                end
                if (isProtected(o, 16'(`LOW_BASE + 16'(j) * 16'h0400 + 16'(i) * 16'h1000))
                    && !isProtected(n, 16'(`LOW_BASE + 16'(j) * 16'h0400
                    + 16'(i) * 16'h1000))) begin
                    ok = 1'b0;
                end
            end
        end
        if (isProtected(o, 16'hf800) && !isProtected(n, 16'hf800)) begin
            ok = 1'b0;
        end
        if (isProtected(o, 16'h8000) && !isProtected(n, 16'h8000)) begin
            ok = 1'b0;
        end
        return ok;
    endfunction

    // ============================================================
    // Next state
    always_comb begin
        logic [7:0] req;
        logic [7:0] cand;
        logic bad;
        req = avsWriteData[7:0];
        cand = cur_q.prot;
        bad = 1'b0;
        nxt_d = cur_q;
        nxt_d.ack = 1'b0;
        nxt_d.accept = 1'b0;
        nxt_d.refuse = 1'b0;
        nvReadReq = 1'b0;
        case (cur_q.st)
            LOAD_REQ: begin
                // Held low while reset is applied, so the request is one clean pulse.
                nvReadReq = rstn; // RULE_05
                nxt_d.st = LOAD_WAIT;
            end
            LOAD_WAIT: begin
                if (nvReadValid) begin
                    nxt_d.prot = nvReadData; // RULE_05
                    nxt_d.st = RUN;
                end
            end
            default: begin
                nxt_d.st = RUN;
            end
        endcase

        // Bus answer: one wait state, then waitrequest is low for one cycle.
        if ((avsRead || avsWrite) && !cur_q.ack && cur_q.st == RUN) begin
            nxt_d.ack = 1'b1;
            nxt_d.rdata = readWord(avsAddress, cur_q.prot, cur_q.viol); // RULE_01
        end

        // A write lands only at the edge where the master sees waitrequest low.
        if (avsWrite && cur_q.ack) begin
            if (avsAddress == `PROT_CTRL_OFFSET) begin
                cand = maskedWrite(cur_q.prot, req); // RULE_02 RULE_03 RULE_04
                if (tighter(cur_q.prot, cand)) begin
                    nxt_d.prot = cand; // RULE_17 RULE_18
                end
            end else if (avsAddress == `STATUS_OFFSET && req[`VIOL_BIT]) begin
                nxt_d.viol = 1'b0; // RULE_19
            end
        end

        // Command check, in the acceptance cycle; a new violation beats a clear.
        if (cmdValid && cur_q.st == RUN) begin
            if (cur_q.viol) begin
                nxt_d.refuse = 1'b1; // RULE_19
            end else begin
                bad = cmdBad(cmdKind, cur_q.prot, cmdAddr); // RULE_20
                nxt_d.refuse = bad;
                nxt_d.accept = !bad;
                if (bad) begin
                    nxt_d.viol = 1'b1; // RULE_07
                end
            end
        end

        if (!rstn) begin
            nxt_d = RESET_STATE;
        end
    end

    always_ff @(posedge clk) begin
        cur_q <= nxt_d;
    end

    // ============================================================
    // Outputs
    assign avsWaitRequest = (avsRead || avsWrite) && !cur_q.ack;
    assign avsReadData = cur_q.rdata;
    assign nvReadAddr = `NV_BYTE_ADDR;
    assign cmdAccept = cur_q.accept;
    assign cmdRefuse = cur_q.refuse;
    assign violation = cur_q.viol;
endmodule

// File: bench/flash_sector_protection_checker.sv
// Concurrent checks on the ports of the flash sector protection block.
// Assumes binding to the design's top module, one clock domain.
module flash_sector_protection_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register bus
    input wire logic [3:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWriteData,
    input wire logic [31:0] avsReadData,
    input wire logic avsWaitRequest,
    // Reset load
    input wire logic nvReadReq,
    input wire logic [15:0] nvReadAddr,
    input wire logic nvReadValid,
    input wire logic [7:0] nvReadData,
    // Commands and status
    input wire logic cmdValid,
    input wire flash_prot_pkg::cmd_kind_e cmdKind,
    input wire logic [15:0] cmdAddr,
    input wire logic cmdAccept,
    input wire logic cmdRefuse,
    input wire logic violation
);
    import flash_prot_pkg::*;
    logic clrHit;
    assign clrHit = avsWrite && !avsWaitRequest && avsAddress == 4'h5 && avsWriteData[5];
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rstn);
    // ============================================================
    // Assertions
    nv_addr_a: assert property (nvReadReq |-> nvReadAddr == 16'hff0d)
        else $error("reset load address wrong");
    nv_pulse_a: assert property (nvReadReq |=> !nvReadReq)
        else $error("reset load request too long");
    rd_pad_a: assert property (avsRead && !avsWaitRequest
        |-> avsReadData[31:8] == 24'h0)
        else $error("read data upper bits set");
    wait_one_a: assert property ((avsRead || avsWrite) && !avsWaitRequest
        |=> !(avsRead || avsWrite) || avsWaitRequest)
        else $error("two answers in a row");
    cmd_excl_a: assert property (!(cmdAccept && cmdRefuse))
        else $error("accept and refuse together");
    cmd_cause_a: assert property (cmdAccept || cmdRefuse |-> $past(cmdValid))
        else $error("answer without command");
    viol_block_a: assert property (cmdValid && violation |=> cmdRefuse && !cmdAccept)
        else $error("command taken while flag set");
    viol_rise_a: assert property ($rose(violation) |-> $past(cmdValid) && cmdRefuse)
        else $error("flag set without refusal");
    viol_clear_a: assert property ($fell(violation) |-> $past(clrHit))
        else $error("flag cleared without write");
    other_ok_a: assert property (cmdValid && cmdKind == CMD_OTHER && !violation
        |=> cmdAccept)
        else $error("plain command refused");
endmodule

bind flash_sector_protection flash_sector_protection_checker chk_u (.clk, .rstn, .avsAddress,
    .avsRead, .avsWrite, .avsWriteData, .avsReadData, .avsWaitRequest, .nvReadReq,
    .nvReadAddr, .nvReadValid, .nvReadData, .cmdValid, .cmdKind, .cmdAddr, .cmdAccept,
    .cmdRefuse, .violation);

// File: bench/flash_sector_protection_tb.sv
// Self-checking testbench for the flash sector protection block.
// Assumes the package, design and checker are compiled before it.
module flash_sector_protection_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import flash_prot_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, avsRead = 1'b0, avsWrite = 1'b0;
    logic nvReadValid = 1'b0, cmdValid = 1'b0, avsWaitRequest, nvReadReq;
    logic cmdAccept, cmdRefuse, violation;
    logic [3:0] avsAddress = 4'h0;
    logic [31:0] avsWriteData = 32'h0, avsReadData, rd;
    logic [15:0] nvReadAddr, cmdAddr = 16'h0;
    logic [7:0] nvReadData = 8'h0;
    cmd_kind_e cmdKind = CMD_PROGRAM;
    int error_cnt = 0, checks = 0;
    always #12.5 clk = ~clk;
    flash_sector_protection dut_u (.clk, .rstn, .avsAddress, .avsRead, .avsWrite,
        .avsWriteData, .avsReadData, .avsWaitRequest, .nvReadReq, .nvReadAddr,
        .nvReadValid, .nvReadData, .cmdValid, .cmdKind, .cmdAddr, .cmdAccept,
        .cmdRefuse, .violation);
    // ============================================================
    // Shared tasks
    task complete_run;
        $display("Counts: %0d checks, %0d mismatches", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
        end
    endtask
    task limit(input int n);
        if (n >= 100) begin
            chk(32'h1, 32'h0);
            complete_run;
        end
    endtask
    task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        int n;
        @(posedge clk);
        avsAddress <= a;
        avsWrite <= w;
        avsRead <= !w;
        avsWriteData <= {24'h0, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avsWaitRequest !== 1'b0 && n < 100);
        limit(n);
        rd = avsReadData;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
    endtask
    task rdchk(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 8'h0);
        chk(rd, e);
    endtask
    task clr;
        bus(1'b1, 4'h5, 8'h20);
    endtask
    task boot(input logic [7:0] b);
        int n;
        rstn <= 1'b0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (nvReadReq !== 1'b1 && n < 100);
        limit(n);
        @(posedge clk);
        nvReadValid <= 1'b1;
        nvReadData <= b;
        @(posedge clk);
        nvReadValid <= 1'b0;
        rdchk(4'h4, {24'h0, b});
    endtask
    task cmd(input cmd_kind_e k, input logic [15:0] a, input logic ok);
        @(posedge clk);
        cmdValid <= 1'b1;
        cmdKind <= k;
        cmdAddr <= a;
        @(posedge clk);
        cmdValid <= 1'b0;
        @(negedge clk);
        chk({29'h0, cmdAccept, cmdRefuse, violation}, {29'h0, ok, !ok, !ok});
    endtask
    // ============================================================
    // Scenarios
    task t_open;
        boot(8'hff);
        rdchk(4'h6, 32'h0);
        cmd(CMD_MASS_ERASE, 16'h0, 1'b1);
        cmd(CMD_SECTOR_ERASE, 16'hff0d, 1'b1);
        cmd(CMD_PROGRAM, 16'hff0d, 1'b1);
        bus(1'b1, 4'h4, 8'h7f);
        rdchk(4'h4, 32'h7f);
        bus(1'b1, 4'h4, 8'hff);
        rdchk(4'h4, 32'h7f);
        cmd(CMD_PROGRAM, 16'h8000, 1'b0);
        bus(1'b1, 4'h5, 8'h0);
        rdchk(4'h5, 32'h20);
        cmd(CMD_OTHER, 16'h0, 1'b0);
        clr;
        rdchk(4'h5, 32'h0);
        cmd(CMD_MASS_ERASE, 16'h0, 1'b0);
        clr;
        cmd(CMD_OTHER, 16'h0, 1'b1);
        $display("Test open and tighten done");
    endtask
    task t_ranges;
        boot(8'hdf);
        cmd(CMD_PROGRAM, 16'hc000, 1'b0);
        clr;
        cmd(CMD_PROGRAM, 16'hbfff, 1'b1);
        bus(1'b1, 4'h4, 8'hc7);
        rdchk(4'h4, 32'hdf);
        bus(1'b1, 4'h4, 8'hde);
        rdchk(4'h4, 32'hde);
        bus(1'b1, 4'h4, 8'hda);
        rdchk(4'h4, 32'hda);
        cmd(CMD_PROGRAM, 16'h4fff, 1'b0);
        clr;
        cmd(CMD_SECTOR_ERASE, 16'h5000, 1'b1);
        bus(1'b1, 4'h4, 8'hd9);
        rdchk(4'h4, 32'hda);
        $display("Test protected ranges done");
    endtask
    task t_unprot;
        boot(8'h7b);
        cmd(CMD_PROGRAM, 16'h5fff, 1'b1);
        cmd(CMD_PROGRAM, 16'h6000, 1'b0);
        clr;
        bus(1'b1, 4'h4, 8'h5b);
        rdchk(4'h4, 32'h7b);
        $display("Test unprotected range done");
    endtask
    initial begin
        t_open;
        t_ranges;
        t_unprot;
        complete_run;
    end
endmodule
